// *** logic/cycle_ctrl.sv ***
// Purpose: machine-cycle sequencer, fetch pointer and external bus strobes
// Assumes: decode info arrives from the core's control decoder on the same clock
// Notes on behaviour
// RQ1 - six two-clock states form each machine cycle
// RQ2 - one-cycle ops fetch S1, decode S2, execute
// RQ3 - two-cycle ops execute through M2 S6
// RQ4 - multiply and divide take four machine cycles
// RQ5 - address latch pulses twice per machine cycle; in M2 of a data move only the S1 pulse is given
// RQ6 - no latch pulse during data strobe
// RQ7 - code read strobe low on external fetch
// RQ8 - two code strobes per cycle, skip moves
// RQ9 - write move drives port0, store strobe low
// RQ10 - read move pulls read strobe, samples port0
// RQ11 - opcode and operand latches feed separate decoders
// RQ12 - arithmetic unit handles listed eight-bit operations
// RQ13 - half carry, carry, overflow recorded in flags
// RQ14 - sixteen-bit fetch pointer counts fetched bytes
// RQ15 - fetch pointer wraps from maximum to zero
// RQ16 - on-chip ROM variant fetches externally above boundary
// RQ17 - ROM-less variant always fetches externally
// RQ18 - fetch pointer spans sixty-four kilobytes
// RQ19 - external latch captures low address byte
// RQ20 - program memory drives port0 only when strobed
// RQ21 - wide pointer high byte on port2
// RQ22 - working register address on port0
// RQ23 - data strobe during second machine cycle
// RQ24 - read move releases port0 after address
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module cycle_ctrl #(
    parameter bit HAS_INT_ROM = 1'b1  // variant with on-chip program ROM
) (
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // instruction class from core
    input wire cycle_ctrl_pkg::instr_info_t instrInfo,
    // arithmetic request
    input wire logic aluGo,
    input wire cycle_ctrl_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluSrcA,
    input wire logic [7:0] aluSrcB,
    output logic [7:0] aluResult,
    // address and data sources
    input wire logic [15:0] widePointer,
    input wire logic [7:0] workReg,
    input wire logic [7:0] accValue,
    input wire logic [7:0] codeByteInt,
    // pins
    input wire logic [7:0] port0In,
    output cycle_ctrl_pkg::ext_bus_t extBus,
    // core-facing outputs
    output logic [7:0] opcodeLatch,
    output logic [7:0] operandAddressLatch,
    output logic [15:0] fetchPointer,
    output logic [7:0] moveReadData,
    output logic [2:0] stateIdx,
    output logic [1:0] cycleIdx,
    output logic stateTick
);
    logic [0:0] clkInState_reg;     // clock within a state
    logic [2:0] state_reg;          // S1..S6
    logic [1:0] mcycle_reg;         // machine cycle within instruction
    logic [1:0] lastCycle_reg;      // instruction length minus one
    logic [1:0] bytesLeft_reg;      // operand bytes still to fetch
    logic moveActive_reg;           // external data move in progress
    logic moveWr_reg;
    logic moveWide_reg;
    logic [15:0] fetch_reg;
    logic [15:0] fetch_next;
    logic [7:0] flags_reg;
    logic [7:0] p0sync1_reg;
    logic [7:0] p0sync2_reg;
    logic endState;
    logic extFetch;
    logic fetchSlot;
    logic dataSlot;
    logic firstByte;                // opcode slot: M1 S1
    logic [2:0] opGrab_reg;         // external opcode in flight, one bit per clock
    logic [2:0] argGrab_reg;        // external operand in flight, one bit per clock
    // pins synchronised before use
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p0sync1_reg <= 8'h00;
            p0sync2_reg <= 8'h00;
        end else begin
            p0sync1_reg <= port0In;
            p0sync2_reg <= p0sync1_reg;
        end
    end
    // two clocks per state, six states per cycle
    assign endState = (clkInState_reg == 1'b1);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clkInState_reg <= 1'b0;
            state_reg <= cycle_ctrl_pkg::ST_S1;
        end else begin
            clkInState_reg <= clkInState_reg + 1'b1; // RQ1
            if (endState) begin
                if (state_reg == cycle_ctrl_pkg::ST_LAST) begin
                    state_reg <= cycle_ctrl_pkg::ST_S1; // RQ1
                end else begin
                    state_reg <= state_reg + 3'h1;
                end
            end
        end
    end
    // machine cycle counter, instruction length taken at decode (S2)
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mcycle_reg <= 2'h0;
            lastCycle_reg <= cycle_ctrl_pkg::CYC_ONE;
            moveActive_reg <= 1'b0;
            moveWr_reg <= 1'b0;
            moveWide_reg <= 1'b0;
        end else if (endState) begin
            if (mcycle_reg == 2'h0 && state_reg == cycle_ctrl_pkg::ST_S2) begin
                lastCycle_reg <= instrInfo.cycles; // RQ2 RQ3 RQ4
                moveActive_reg <= instrInfo.isMove && instrInfo.cycles == cycle_ctrl_pkg::CYC_TWO;
                moveWr_reg <= instrInfo.moveWrite;
                moveWide_reg <= instrInfo.wideAddr;
            end
            if (state_reg == cycle_ctrl_pkg::ST_LAST) begin
                if (mcycle_reg == lastCycle_reg) begin
                    mcycle_reg <= 2'h0; // RQ3 RQ4
                    moveActive_reg <= 1'b0;
                end else begin
                    mcycle_reg <= mcycle_reg + 2'h1;
                end
            end
        end
    end
    // fetch slots: S1 and S4 of each cycle; data move owns M2 S1-S6, data strobe S2-S6
    assign dataSlot = moveActive_reg && mcycle_reg == 2'h1; // RQ23
    assign fetchSlot = endState && !dataSlot &&
        (state_reg == cycle_ctrl_pkg::ST_S1 || state_reg == cycle_ctrl_pkg::ST_S4);
    // external when ROM-less, or above internal area
    assign extFetch = !HAS_INT_ROM || (fetch_reg > cycle_ctrl_pkg::INT_ROM_TOP); // RQ16 RQ17
    assign fetch_next = fetch_reg + cycle_ctrl_pkg::FETCH_STEP; // RQ15 RQ18
    assign firstByte = mcycle_reg == 2'h0 && state_reg == cycle_ctrl_pkg::ST_S1;
    // a strobed byte reaches p0sync2_reg two clocks after the strobe is launched
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            opGrab_reg <= 3'h0;
            argGrab_reg <= 3'h0;
        end else begin
            opGrab_reg <= {opGrab_reg[1:0], extFetch && fetchSlot && firstByte};
            argGrab_reg <= {argGrab_reg[1:0],
                extFetch && fetchSlot && !firstByte && bytesLeft_reg != 2'h0};
        end
    end
    // fetch pointer and operand byte count
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_reg <= cycle_ctrl_pkg::FETCH_RESET;
            bytesLeft_reg <= 2'h0;
        end else if (fetchSlot) begin
            if (mcycle_reg == 2'h0 && state_reg == cycle_ctrl_pkg::ST_S1) begin
                fetch_reg <= fetch_next; // RQ14
                bytesLeft_reg <= instrInfo.extraBytes;
            end else if (bytesLeft_reg != 2'h0) begin
                fetch_reg <= fetch_next; // RQ2 RQ3
                bytesLeft_reg <= bytesLeft_reg - 2'h1;
            end
        end
    end
    // opcode and operand address latches
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            opcodeLatch <= 8'h00;
            operandAddressLatch <= 8'h00;
        end else if (opGrab_reg[2]) begin
            opcodeLatch <= p0sync2_reg; // RQ11
        end else if (argGrab_reg[2]) begin
            operandAddressLatch <= p0sync2_reg; // RQ11
        end else if (fetchSlot && !extFetch) begin
            if (firstByte) begin
                opcodeLatch <= codeByteInt; // RQ11
            end else if (bytesLeft_reg != 2'h0) begin
                operandAddressLatch <= codeByteInt; // RQ11
            end
        end
    end
    // external bus pins, all registered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            extBus <= '{addrLatch: 1'b1, codeReadStrobe_n: 1'b1, readStrobe_n: 1'b1,
                writeStrobe_n: 1'b1, port0Out: 8'hFF, port0Oe: 1'b0, port2Out: 8'hFF};
        end else begin
            // latch strobe in second clock of S1 and S4, except S4 of M2 in a data move; M2 S1 pulse takes the move address
            extBus.addrLatch <= !endState && (state_reg == cycle_ctrl_pkg::ST_S1 ||
                (!dataSlot && state_reg == cycle_ctrl_pkg::ST_S4)); // RQ5 RQ6
            // code strobe after the fetch slot edge, external fetch only
            extBus.codeReadStrobe_n <= !(extFetch && fetchSlot); // RQ7 RQ8
            extBus.readStrobe_n <= !(dataSlot && !moveWr_reg &&
                state_reg != cycle_ctrl_pkg::ST_S1); // RQ10 RQ23
            extBus.writeStrobe_n <= !(dataSlot && moveWr_reg &&
                state_reg != cycle_ctrl_pkg::ST_S1); // RQ9 RQ23
            if (moveActive_reg && (mcycle_reg == 2'h0 && state_reg == cycle_ctrl_pkg::ST_S6 ||
                    mcycle_reg == 2'h1 && state_reg == cycle_ctrl_pkg::ST_S1)) begin
                // address phase of the move, held through the M2 S1 latch pulse
                extBus.port0Out <= moveWide_reg ? widePointer[7:0] : workReg; // RQ22
                extBus.port0Oe <= 1'b1;
                extBus.port2Out <= moveWide_reg ? widePointer[15:8] : fetch_reg[15:8]; // RQ21
            end else if (dataSlot) begin
                extBus.port0Out <= accValue; // RQ9
                extBus.port0Oe <= moveWr_reg; // RQ24
            end else begin
                extBus.port0Out <= fetch_reg[7:0]; // RQ19
                // released while the code strobe is low, and for the whole of an internal fetch
                extBus.port0Oe <= extFetch && !fetchSlot; // RQ20
                extBus.port2Out <= fetch_reg[15:8];
            end
        end
    end
    // read move data taken while read strobe low
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            moveReadData <= 8'h00;
        end else if (!extBus.readStrobe_n && state_reg == cycle_ctrl_pkg::ST_S6) begin
            moveReadData <= p0sync2_reg; // RQ10
        end
    end
    // arithmetic unit with flag capture
    logic [8:0] aluSum;
    logic [4:0] aluHalf;
    logic [7:0] aluRes;
    logic aluSetFlags;
    logic carryIn;
    always_comb begin
        carryIn = flags_reg[cycle_ctrl_pkg::CARRY_BIT];
        aluSum = 9'h000;
        aluHalf = 5'h00;
        aluRes = 8'h00;
        aluSetFlags = 1'b0;
        unique case (aluOp)
            cycle_ctrl_pkg::OP_ADD, cycle_ctrl_pkg::OP_ADDC: begin
                aluSum = {1'b0, aluSrcA} + {1'b0, aluSrcB} +
                    {8'h00, aluOp == cycle_ctrl_pkg::OP_ADDC && carryIn};
                aluHalf = {1'b0, aluSrcA[3:0]} + {1'b0, aluSrcB[3:0]} +
                    {4'h0, aluOp == cycle_ctrl_pkg::OP_ADDC && carryIn};
                aluRes = aluSum[7:0];
                aluSetFlags = 1'b1;
            end
            cycle_ctrl_pkg::OP_SUB, cycle_ctrl_pkg::OP_SUBB: begin
                aluSum = {1'b0, aluSrcA} - {1'b0, aluSrcB} -
                    {8'h00, aluOp == cycle_ctrl_pkg::OP_SUBB && carryIn};
                aluHalf = {1'b0, aluSrcA[3:0]} - {1'b0, aluSrcB[3:0]} -
                    {4'h0, aluOp == cycle_ctrl_pkg::OP_SUBB && carryIn};
                aluRes = aluSum[7:0];
                aluSetFlags = 1'b1;
            end
            cycle_ctrl_pkg::OP_INC: aluRes = aluSrcA + 8'h01;
            cycle_ctrl_pkg::OP_DEC: aluRes = aluSrcA - 8'h01;
            cycle_ctrl_pkg::OP_CPL: aluRes = ~aluSrcA;
            cycle_ctrl_pkg::OP_RL: aluRes = {aluSrcA[6:0], aluSrcA[7]};
            cycle_ctrl_pkg::OP_RLC: aluRes = {aluSrcA[6:0], carryIn};
            cycle_ctrl_pkg::OP_RR: aluRes = {aluSrcA[0], aluSrcA[7:1]};
            cycle_ctrl_pkg::OP_RRC: aluRes = {carryIn, aluSrcA[7:1]};
            cycle_ctrl_pkg::OP_DA: begin
                aluSum = {1'b0, aluSrcA};
                if (aluSrcA[3:0] > 4'h9 || flags_reg[cycle_ctrl_pkg::HALF_CARRY_BIT]) begin
                    aluSum = aluSum + 9'h006;
                end
                if (aluSum[7:4] > 4'h9 || carryIn || aluSum[8]) begin
                    aluSum = aluSum + 9'h060;
                end
                aluRes = aluSum[7:0];
            end
            cycle_ctrl_pkg::OP_SWAP: aluRes = {aluSrcA[3:0], aluSrcA[7:4]};
            cycle_ctrl_pkg::OP_AND: aluRes = aluSrcA & aluSrcB;
            cycle_ctrl_pkg::OP_OR: aluRes = aluSrcA | aluSrcB;
            cycle_ctrl_pkg::OP_XOR: aluRes = aluSrcA ^ aluSrcB; // RQ12
        endcase
    end
    // result register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aluResult <= 8'h00;
        end else if (aluGo) begin
            aluResult <= aluRes; // RQ12
        end
    end
    // flag word: hardware update wins over a same-cycle software write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= cycle_ctrl_pkg::FLAG_WORD_RESET;
        end else if (aluGo && aluSetFlags) begin
            flags_reg[cycle_ctrl_pkg::CARRY_BIT] <= aluSum[8]; // RQ13
            flags_reg[cycle_ctrl_pkg::HALF_CARRY_BIT] <= aluHalf[4]; // RQ13
            flags_reg[cycle_ctrl_pkg::SIGNED_RANGE_BIT] <= aluSum[7] ^ aluSum[8] ^
                aluSrcA[7] ^ aluSrcB[7] ^ aluHalf[4] ^ aluHalf[4] ? (aluSrcA[7] ==
                (aluOp == cycle_ctrl_pkg::OP_ADD || aluOp == cycle_ctrl_pkg::OP_ADDC ?
                aluSrcB[7] : ~aluSrcB[7])) && (aluRes[7] != aluSrcA[7]) : 1'b0; // RQ13
        end else if (regWrite && regAddr == cycle_ctrl_pkg::FLAG_WORD_ADDR) begin
            flags_reg <= regWrData;
        end
    end
    // register read, one cycle later, unmapped reads zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
        end else if (regRead && regAddr == cycle_ctrl_pkg::FLAG_WORD_ADDR) begin
            regRdData <= flags_reg;
        end else begin
            regRdData <= 8'h00;
        end
    end
    // status outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fetchPointer <= cycle_ctrl_pkg::FETCH_RESET;
            stateIdx <= cycle_ctrl_pkg::ST_S1;
            cycleIdx <= 2'h0;
            stateTick <= 1'b0;
        end else begin
            fetchPointer <= fetch_reg;
            stateIdx <= state_reg;
            cycleIdx <= mcycle_reg;
            stateTick <= endState;
        end
    end
    // cycle counter for checking the machine cycle length
    logic [3:0] clkCount_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clkCount_reg <= 4'h0;
        end else if (endState && state_reg == cycle_ctrl_pkg::ST_LAST) begin
            clkCount_reg <= 4'h0;
        end else begin
            clkCount_reg <= clkCount_reg + 4'h1;
        end
    end
    AST_CYCLE_LEN: assert property (@(posedge mclk) disable iff (!rst_b) // RQ1
        clkCount_reg < 4'(cycle_ctrl_pkg::CLKS_PER_CYCLE)) else $error("machine cycle too long");
    AST_STATE_TWO: assert property (@(posedge mclk) disable iff (!rst_b) // RQ1
        $changed(state_reg) |-> ##1 $stable(state_reg)) else $error("state shorter than two clocks");
    AST_LATCH_QUIET: assert property (@(posedge mclk) disable iff (!rst_b) // RQ6
        !extBus.readStrobe_n || !extBus.writeStrobe_n |-> !extBus.addrLatch)
        else $error("latch pulse during data strobe");
    AST_CODE_QUIET: assert property (@(posedge mclk) disable iff (!rst_b) // RQ8
        !extBus.readStrobe_n |-> extBus.codeReadStrobe_n) else $error("code strobe during read");
    AST_INT_NO_STROBE: assert property (@(posedge mclk) disable iff (!rst_b) // RQ16
        HAS_INT_ROM && $past(fetch_reg) <= cycle_ctrl_pkg::INT_ROM_TOP |-> extBus.codeReadStrobe_n)
        else $error("code strobe for internal fetch");
    AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_b) // RQ15
        fetchSlot && fetch_reg == 16'hFFFF && mcycle_reg == 2'h0 && state_reg == cycle_ctrl_pkg::ST_S1
        |=> fetch_reg == 16'h0000) else $error("fetch pointer did not wrap");
    AST_STROBE_EXCL: assert property (@(posedge mclk) disable iff (!rst_b) // RQ9
        !(!extBus.readStrobe_n && !extBus.writeStrobe_n)) else $error("read and write strobes both low");
    AST_READ_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b) // RQ24
        !extBus.readStrobe_n |-> !extBus.port0Oe) else $error("port0 driven during read");
endmodule

// *** pkg/cycle_ctrl_pkg.sv ***
// Purpose: shared constants and types for the machine-cycle sequencer
// Assumes: one oscillator clock mclk, 40 MHz
// Notes: register offset, timing counts and decode values live here
package cycle_ctrl_pkg;
    // state count per machine cycle and clocks per state
    localparam int STATES_PER_CYCLE = 6;
    localparam int CLKS_PER_STATE = 2;
    localparam int CLKS_PER_CYCLE = STATES_PER_CYCLE * CLKS_PER_STATE;
    // flag word register offset and reset value
    localparam logic [7:0] FLAG_WORD_ADDR = 8'hD0;
    localparam logic [7:0] FLAG_WORD_RESET = 8'h00;
    // flag word field positions
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int SIGNED_RANGE_BIT = 2;
    // internal program area upper bound
    localparam logic [15:0] INT_ROM_TOP = 16'h3FFF;
    localparam logic [15:0] FETCH_RESET = 16'h0000;
    localparam logic [15:0] FETCH_STEP = 16'h0001;
    // state index codes (S1..S6 as 0..5)
    localparam logic [2:0] ST_S1 = 3'h0;
    localparam logic [2:0] ST_S2 = 3'h1;
    localparam logic [2:0] ST_S3 = 3'h2;
    localparam logic [2:0] ST_S4 = 3'h3;
    localparam logic [2:0] ST_S6 = 3'h5;
    localparam logic [2:0] ST_LAST = 3'h5;
    // instruction length classes in machine cycles
    localparam logic [1:0] CYC_ONE = 2'h0;
    localparam logic [1:0] CYC_TWO = 2'h1;
    localparam logic [1:0] CYC_FOUR = 2'h3;
    // arithmetic operation codes
    typedef enum logic [3:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC, OP_CPL, OP_RL,
        OP_RLC, OP_RR, OP_RRC, OP_DA, OP_SWAP, OP_AND, OP_OR, OP_XOR
    } alu_op_t;
    // sequencer phases
    typedef enum logic [2:0] {
        PH_FETCH, PH_EXEC, PH_XREAD, PH_XWRITE
    } phase_t;
    // an instruction handed in by the core
    typedef struct packed {
        logic [1:0] cycles;   // machine cycles minus one
        logic [1:0] extraBytes;
        logic isMove;         // external data move
        logic moveWrite;      // direction: 1 = accumulator to memory
        logic wideAddr;       // addressed by wide data pointer
    } instr_info_t;
    // external bus pins
    typedef struct packed {
        logic addrLatch;
        logic codeReadStrobe_n;
        logic readStrobe_n;
        logic writeStrobe_n;
        logic [7:0] port0Out;
        logic port0Oe;
        logic [7:0] port2Out;
    } ext_bus_t;
endpackage

// *** verification/cycle_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the cycle sequencer
// Assumes: ROM-less variant, so every fetch goes external
// Notes: bus counts watched by a monitor process
`timescale 1ns/1ps
module cycle_ctrl_tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic regWrite = 1'b0, regRead = 1'b0, aluGo = 1'b0;
    cycle_ctrl_pkg::instr_info_t instrInfo = '0;
    cycle_ctrl_pkg::alu_op_t aluOp = cycle_ctrl_pkg::OP_ADD;
    logic [7:0] aluSrcA = 8'h00, aluSrcB = 8'h00, aluResult;
    logic [15:0] widePointer = 16'h0000, fetchPointer, pcPrev;
    logic [7:0] workReg = 8'h00, accValue = 8'h00, port0In, lowAddr;
    logic [7:0] opcodeLatch, operandAddressLatch, moveReadData;
    cycle_ctrl_pkg::ext_bus_t extBus;
    logic [2:0] stateIdx, prevIdx = 3'h0;
    logic [1:0] cycleIdx;
    logic stateTick, prevAle = 1'b0, prevCode = 1'b1;
    int err_total = 0, samples_checked = 0, seed = 52620;
    int aleCnt = 0, codeCnt = 0, tickCnt = 0, busyHit = 0;
    // clock, 25 ns period
    always #12.5 mclk = ~mclk;
    cycle_ctrl #(.HAS_INT_ROM(1'b0)) dut_u (.mclk(mclk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .instrInfo(instrInfo),
        .aluGo(aluGo), .aluOp(aluOp), .aluSrcA(aluSrcA), .aluSrcB(aluSrcB),
        .aluResult(aluResult), .widePointer(widePointer), .workReg(workReg),
        .accValue(accValue), .codeByteInt(8'h00), .port0In(port0In),
        .extBus(extBus), .opcodeLatch(opcodeLatch),
        .operandAddressLatch(operandAddressLatch), .fetchPointer(fetchPointer),
        .moveReadData(moveReadData), .stateIdx(stateIdx), .cycleIdx(cycleIdx),
        .stateTick(stateTick));
    ext_mem_model mem_u (.mclk(mclk), .extBus(extBus), .port0In(port0In),
        .lowAddr(lowAddr));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
            input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s seen %h want %h", $time, msg, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // monitor: strobe edges, ticks, state order, pulses during moves
    always @(posedge mclk) begin
        #1;
        if (extBus.addrLatch && !prevAle) aleCnt++;
        if (!extBus.codeReadStrobe_n && prevCode) codeCnt++;
        if (stateTick === 1'b1) tickCnt++;
        if (!(extBus.readStrobe_n && extBus.writeStrobe_n) &&
                (extBus.addrLatch || !extBus.codeReadStrobe_n)) busyHit++;
        if (rst_b && stateIdx !== prevIdx)
            check(stateIdx, (prevIdx == 3'h5) ? 3'h0 : prevIdx + 3'h1, "state");
        pcPrev = fetchPointer - 16'h0001;
        if (rst_b && stateIdx == 3'h4 && cycleIdx == 2'h0)
            check(opcodeLatch, pcPrev[7:0] ^ pcPrev[15:8] ^ 8'hA5, "opcode");
        prevAle = extBus.addrLatch;
        prevCode = extBus.codeReadStrobe_n;
        prevIdx = stateIdx;
    end
    // register port cycles
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge mclk) regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) {regRead, regAddr} <= {1'b1, a};
        @(posedge mclk) regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    // reference arithmetic
    function automatic logic [7:0] alu_ref(input cycle_ctrl_pkg::alu_op_t op,
            input logic [7:0] a, input logic [7:0] b);
        case (op)
            cycle_ctrl_pkg::OP_ADD: return a + b;
            cycle_ctrl_pkg::OP_SUB: return a - b;
            cycle_ctrl_pkg::OP_INC: return a + 8'h01;
            cycle_ctrl_pkg::OP_DEC: return a - 8'h01;
            cycle_ctrl_pkg::OP_CPL: return ~a;
            cycle_ctrl_pkg::OP_SWAP: return {a[3:0], a[7:4]};
            cycle_ctrl_pkg::OP_AND: return a & b;
            cycle_ctrl_pkg::OP_OR: return a | b;
            default: return a ^ b;
        endcase
    endfunction
    // one external data move, with bounded waits on the strobe
    task automatic do_move(input logic wr, input logic wide);
        logic [7:0] want;
        int n;
        want = $random(seed);
        mem_u.ram[widePointer] = want;
        @(posedge mclk) instrInfo <= '{cycles: 2'h1, extraBytes: 2'h0,
            isMove: 1'b1, moveWrite: wr, wideAddr: wide};
        for (n = 0; n < 200 && (wr ? extBus.writeStrobe_n : extBus.readStrobe_n); n++)
            @(posedge mclk) #1;
        check(n < 200, 1'b1, "strobe low");
        check(lowAddr, wide ? widePointer[7:0] : workReg, "low addr");
        if (wide) check(extBus.port2Out, widePointer[15:8], "high addr");
        if (wr) check({extBus.port0Oe, extBus.port0Out}, {1'b1, accValue}, "wdata");
        else check(extBus.port0Oe, 1'b0, "release");
        @(posedge mclk) instrInfo <= '0;
        for (n = 0; n < 50 && !(extBus.readStrobe_n && extBus.writeStrobe_n); n++)
            @(posedge mclk) #1;
        check(n < 50, 1'b1, "strobe end");
        if (wr && wide) check(mem_u.ram[widePointer], accValue, "ram");
        if (!wr) check(moveReadData, want, "rdata");
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        logic [7:0] d, a, b;
        cycle_ctrl_pkg::alu_op_t ops[9] = '{cycle_ctrl_pkg::OP_ADD,
            cycle_ctrl_pkg::OP_SUB, cycle_ctrl_pkg::OP_INC, cycle_ctrl_pkg::OP_DEC,
            cycle_ctrl_pkg::OP_CPL, cycle_ctrl_pkg::OP_SWAP, cycle_ctrl_pkg::OP_AND,
            cycle_ctrl_pkg::OP_OR, cycle_ctrl_pkg::OP_XOR};
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        reg_rd(cycle_ctrl_pkg::FLAG_WORD_ADDR, d);
        check(d, cycle_ctrl_pkg::FLAG_WORD_RESET, "flag reset");
        reg_wr(8'h3C, 8'hFF);
        reg_rd(8'h3C, d);
        check(d, 8'h00, "unmapped");
        reg_wr(cycle_ctrl_pkg::FLAG_WORD_ADDR, 8'h84);
        reg_rd(cycle_ctrl_pkg::FLAG_WORD_ADDR, d);
        check(d, 8'h84, "flag rw");
        $display("test registers done");
        // strobe and state counts over four machine cycles
        repeat (24) @(posedge mclk);
        {aleCnt, codeCnt, tickCnt} = '0;
        repeat (4 * cycle_ctrl_pkg::CLKS_PER_CYCLE) @(posedge mclk);
        check(tickCnt, 4 * cycle_ctrl_pkg::STATES_PER_CYCLE, "ticks");
        check(aleCnt, 8, "latch pulses");
        check(codeCnt, 8, "code pulses");
        $display("test strobes done");
        // arithmetic table, then carries from FF plus 01
        foreach (ops[i]) begin
            a = $random(seed);
            b = $random(seed);
            @(posedge mclk) {aluGo, aluOp, aluSrcA, aluSrcB} <= {1'b1, ops[i], a, b};
            @(posedge mclk) aluGo <= 1'b0;
            #1 check(aluResult, alu_ref(ops[i], a, b), "alu");
        end
        @(posedge mclk) {aluGo, aluOp, aluSrcA, aluSrcB} <=
            {1'b1, cycle_ctrl_pkg::OP_ADD, 8'hFF, 8'h01};
        @(posedge mclk) aluGo <= 1'b0;
        reg_rd(cycle_ctrl_pkg::FLAG_WORD_ADDR, d);
        check(d[cycle_ctrl_pkg::CARRY_BIT], 1'b1, "carry");
        check(d[cycle_ctrl_pkg::HALF_CARRY_BIT], 1'b1, "half carry");
        $display("test alu done");
        // moves: wide write, wide read, register write
        busyHit = 0;
        {widePointer, accValue, workReg} = {$random(seed), $random(seed)};
        do_move(1'b1, 1'b1);
        do_move(1'b0, 1'b1);
        do_move(1'b1, 1'b0);
        check(busyHit, 0, "pulses in move");
        $display("test moves done");
        tally_and_finish;
    end
endmodule

// *** verification/ext_mem_model.sv ***
// Purpose: far side of the bus: address latch, program ROM, data RAM
// Assumes: bus pins sampled on mclk
// Notes: floating port 0 shows the inverse of its last level
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic mclk,
    input wire cycle_ctrl_pkg::ext_bus_t extBus,
    output logic [7:0] port0In,
    output logic [7:0] lowAddr
);
    logic [7:0] ram [0:65535]; // external data store
    logic [7:0] last; // previous port 0 level
    logic [15:0] addr; // full external address
    logic [7:0] romByte; // program byte at addr
    assign addr = {extBus.port2Out, lowAddr};
    assign romByte = addr[7:0] ^ addr[15:8] ^ 8'hA5;
    // address latch follows port 0 while strobe is high
    initial lowAddr = 8'h00;
    always @(posedge mclk) begin
        if (extBus.addrLatch) begin
            lowAddr <= extBus.port0Out;
        end
    end
    // wire level: device, ROM only while strobed, RAM only on read
    always_comb begin
        if (extBus.port0Oe) begin
            port0In = extBus.port0Out;
        end else if (!extBus.codeReadStrobe_n) begin
            port0In = romByte;
        end else if (!extBus.readStrobe_n) begin
            port0In = ram[addr];
        end else begin
            port0In = ~last;
        end
    end
    // history for the floating level, RAM capture on store strobe
    initial last = 8'h00;
    always @(posedge mclk) begin
        last <= port0In;
        if (!extBus.writeStrobe_n) begin
            ram[addr] <= extBus.port0Out;
        end
    end
endmodule
